// [include/temp_sensor_consts.vh]
/*
 * Constants of the temperature sensor register bank: command codes,
 * field positions, reset values and conversion interval timing.
 * Assumes inclusion by the register bank module only; definitions only.
 */
`ifndef TEMP_SENSOR_CONSTS_VH
`define TEMP_SENSOR_CONSTS_VH

// ==========================================================
// command codes
`define ADDR_LOCAL_INT 8'h00
`define ADDR_RS_INT 8'h01
`define ADDR_GCFG_A 8'h03
`define ADDR_GCFG_B 8'h09
`define ADDR_RATE_A 8'h04
`define ADDR_RATE_B 8'h0a
`define ADDR_ONESHOT 8'h0f
`define ADDR_RS_FRAC 8'h10
`define ADDR_OFS_HI 8'h11
`define ADDR_OFS_LO 8'h12
`define ADDR_LOCAL_FRAC 8'h30
`define ADDR_RU_INT 8'h31
`define ADDR_RU_FRAC 8'h32
`define ADDR_DCFG 8'hbf

// ==========================================================
// field positions
`define DCFG_ROLE 6
`define DCFG_FMASK_OT 5
`define DCFG_FMASK_CRIT 4
`define DCFG_MODEL 3
`define DCFG_FILT_HI 2
`define DCFG_FILT_LO 1
`define GCFG_STANDBY 6
`define GCFG_MASK_RCRIT 4
`define GCFG_MASK_ROT 3
`define GCFG_MASK_LCRIT 2
`define GCFG_MASK_LOT 1

// ==========================================================
// reset values and writable bits
`define DCFG_RST 8'h1f
`define GCFG_RST 8'h00
`define GCFG_WMASK 8'h5e
`define RATE_RST 8'h02
`define RATE_WMASK 8'h03
`define OFS_RST 8'h00
`define OFS_LO_WMASK 8'he0
`define FILT_ON 2'h3

// ==========================================================
// result codes
`define S_FAULT_INT 8'h80
`define S_MAX_INT 8'h7f
`define U_MAX_INT 8'hff
`define RAW_FRAC_MAX 5'h1f

// ==========================================================
// timing
`define CLK_MHZ 30'd250
`define T_RATE1_US 30'd364000
`define T_RATE2_US 30'd1000000
`define T_RATE3_US 30'd2500000

`endif

// [rtl/temp_sensor_reg_bank.v]
/*
 * Register bank of a local and remote diode temperature monitor:
 * result registers with fraction locking, diode and general config,
 * remote offset, conversion interval timer and one-shot trigger.
 * Assumes an SMBus target decodes bytes into single-cycle read and
 * write strobes with a command code, and that the analog converter
 * and limit comparators run on clk_in and answer with conv_done_in.
 */
`timescale 1ns/100ps
`include "temp_sensor_consts.vh"

module temp_sensor_reg_bank #(
    parameter [29:0] RATE1_CYCLES = `T_RATE1_US * `CLK_MHZ,
    parameter [29:0] RATE2_CYCLES = `T_RATE2_US * `CLK_MHZ,
    parameter [29:0] RATE3_CYCLES = `T_RATE3_US * `CLK_MHZ
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // register access from the smbus target
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    // converter
    output reg conv_start_out,
    output wire conv_busy_out,
    input wire conv_done_in,
    input wire [10:0] local_raw_in,
    input wire [14:0] remote_raw_in,
    input wire diode_fault_in,
    // limit comparisons
    input wire local_overtemp_in,
    input wire local_crit_in,
    input wire remote_overtemp_in,
    input wire remote_crit_in,
    // converter control
    output reg diode_model_select_out,
    output reg remote_filter_en_out,
    output reg standby_out,
    // shared pin, open drain, and critical output
    input wire addr_select_pin_in,
    output reg overtemp_shutdown_out,
    output reg overtemp_shutdown_oe_n_out,
    output reg addr_select_level_out,
    output reg crit_alarm_out
);

    localparam [1:0] ST_STANDBY = 2'd0;
    localparam [1:0] ST_WAIT = 2'd1;
    localparam [1:0] ST_CONV = 2'd2;

    // ==========================================================
    // functions

    // place raw fraction bits; filter off drops the two finest bits
    function [7:0] frac_fmt;
        input [4:0] raw;
        input filt;
        begin
            frac_fmt = filt ? {raw, 3'b000} : {raw[4:2], 5'b00000};
        end
    endfunction

    function [29:0] interval_cycles;
        input [1:0] rate;
        begin
            case (rate)
                2'd0: interval_cycles = 30'h0;
                2'd1: interval_cycles = RATE1_CYCLES - 30'h1;
                2'd2: interval_cycles = RATE2_CYCLES - 30'h1;
                default: interval_cycles = RATE3_CYCLES - 30'h1;
            endcase
        end
    endfunction

    // ==========================================================
    // registers

    reg [7:0] dcfg_q;
    reg [7:0] gcfg_q;
    reg [7:0] rate_q;
    reg [7:0] ofs_hi_q;
    reg [7:0] ofs_lo_q;
    reg [7:0] loc_int_q;
    reg [2:0] loc_frac_q;
    reg [7:0] rs_int_q;
    reg [4:0] rs_frac_q;
    reg [7:0] ru_int_q;
    reg [4:0] ru_frac_q;
    reg loc_lock_q;
    reg rs_lock_q;
    reg ru_lock_q;
    reg [7:0] loc_hold_q;
    reg [7:0] rs_hold_q;
    reg [7:0] ru_hold_q;
    reg [1:0] state_q;
    reg [29:0] cnt_q;
    reg pin_s1_q;
    reg pin_s2_q;
    reg pin_s3_q;

    wire filt_on;
    wire standby;
    wire wr_gcfg;
    wire wr_rate;
    wire oneshot_wr;
    assign filt_on = (dcfg_q[`DCFG_FILT_HI:`DCFG_FILT_LO] == `FILT_ON);
    assign standby = gcfg_q[`GCFG_STANDBY];
    assign wr_gcfg = reg_wr_in && (reg_addr_in == `ADDR_GCFG_A ||
        reg_addr_in == `ADDR_GCFG_B);
    assign wr_rate = reg_wr_in && (reg_addr_in == `ADDR_RATE_A ||
        reg_addr_in == `ADDR_RATE_B);
    assign oneshot_wr = reg_wr_in && (reg_addr_in == `ADDR_ONESHOT);
    assign conv_busy_out = (state_q == ST_CONV);

    // ==========================================================
    // remote result arithmetic

    wire [14:0] ofs_ext;
    wire [15:0] sum;
    wire neg;
    wire s_over;
    wire s_under;
    wire u_over;
    // offset in eighths scaled to the raw 1/32 degree grid
    assign ofs_ext = {{2{ofs_hi_q[7]}}, ofs_hi_q, ofs_lo_q[7:5], 2'b00};
    assign sum = {remote_raw_in[14], remote_raw_in} +
        {ofs_ext[14], ofs_ext};
    assign neg = sum[15];
    assign s_over = !neg && (|sum[14:12]);
    assign s_under = neg && !(&sum[14:12]);
    assign u_over = !neg && (|sum[14:13]);

    // ==========================================================
    // configuration writes

    always @(posedge clk_in) begin
        if (rst_in) begin
            dcfg_q <= `DCFG_RST;
            gcfg_q <= `GCFG_RST;
            rate_q <= `RATE_RST;
            ofs_hi_q <= `OFS_RST;
            ofs_lo_q <= `OFS_RST;
        end else begin
            if (reg_wr_in && reg_addr_in == `ADDR_DCFG) begin
                // bit 7 held at 0 and bit 0 at 1
                dcfg_q <= {1'b0, reg_wdata_in[6:1], 1'b1};
            end
            if (wr_gcfg) begin
                gcfg_q <= reg_wdata_in & `GCFG_WMASK;
            end
            if (wr_rate) begin
                rate_q <= reg_wdata_in & `RATE_WMASK;
            end
            if (reg_wr_in && reg_addr_in == `ADDR_OFS_HI) begin
                ofs_hi_q <= reg_wdata_in;
            end
            if (reg_wr_in && reg_addr_in == `ADDR_OFS_LO) begin
                ofs_lo_q <= reg_wdata_in & `OFS_LO_WMASK;
            end
        end
    end

    // ==========================================================
    // conversion sequencer

    always @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ST_WAIT;
            cnt_q <= 30'h0;
            conv_start_out <= 1'b0;
        end else begin
            conv_start_out <= 1'b0;
            if (cnt_q != 30'h0) begin
                cnt_q <= cnt_q - 30'h1;
            end
            case (state_q)
                ST_STANDBY: begin
                    if (!standby) begin
                        state_q <= ST_WAIT;
                        cnt_q <= 30'h0;
                    end else if (oneshot_wr) begin
                        // one-shot honoured only here, in standby
                        conv_start_out <= 1'b1;
                        state_q <= ST_CONV;
                    end
                end
                ST_WAIT: begin
                    if (standby) begin
                        state_q <= ST_STANDBY;
                    end else if (cnt_q == 30'h0) begin
                        // count loaded one short, so starts fall a full interval apart
                        conv_start_out <= 1'b1;
                        cnt_q <= interval_cycles(rate_q[1:0]);
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done_in) begin
                        if (standby) begin
                            state_q <= ST_STANDBY;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                default: state_q <= ST_WAIT;
            endcase
        end
    end

    // ==========================================================
    // result capture

    always @(posedge clk_in) begin
        if (rst_in) begin
            loc_int_q <= 8'h00;
            loc_frac_q <= 3'h0;
            rs_int_q <= 8'h00;
            rs_frac_q <= 5'h00;
            ru_int_q <= 8'h00;
            ru_frac_q <= 5'h00;
        end else if (conv_done_in && state_q == ST_CONV) begin
            loc_int_q <= local_raw_in[10:3];
            loc_frac_q <= local_raw_in[2:0];
            if (diode_fault_in) begin
                rs_int_q <= `S_FAULT_INT;
                rs_frac_q <= 5'h00;
                ru_int_q <= 8'h00;
                ru_frac_q <= 5'h00;
            end else begin
                if (s_over) begin
                    rs_int_q <= `S_MAX_INT;
                    rs_frac_q <= `RAW_FRAC_MAX;
                end else if (s_under) begin
                    rs_int_q <= `S_FAULT_INT;
                    rs_frac_q <= 5'h00;
                end else begin
                    rs_int_q <= sum[12:5];
                    rs_frac_q <= sum[4:0];
                end
                if (neg) begin
                    ru_int_q <= 8'h00;
                    ru_frac_q <= 5'h00;
                end else if (u_over) begin
                    ru_int_q <= `U_MAX_INT;
                    ru_frac_q <= `RAW_FRAC_MAX;
                end else begin
                    ru_int_q <= sum[12:5];
                    ru_frac_q <= sum[4:0];
                end
            end
        end
    end

    // ==========================================================
    // fraction locking

    // a lock freezes the formatted byte, so a later filter change does
    // not alter a value the host is midway through reading
    always @(posedge clk_in) begin
        if (rst_in) begin
            loc_lock_q <= 1'b0;
            rs_lock_q <= 1'b0;
            ru_lock_q <= 1'b0;
            loc_hold_q <= 8'h00;
            rs_hold_q <= 8'h00;
            ru_hold_q <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ADDR_LOCAL_INT: begin
                    loc_lock_q <= 1'b1;
                    loc_hold_q <= {loc_frac_q, 5'b00000};
                end
                `ADDR_RS_INT: begin
                    rs_lock_q <= 1'b1;
                    rs_hold_q <= frac_fmt(rs_frac_q, filt_on);
                end
                `ADDR_RU_INT: begin
                    ru_lock_q <= 1'b1;
                    ru_hold_q <= frac_fmt(ru_frac_q, filt_on);
                end
                `ADDR_LOCAL_FRAC: loc_lock_q <= 1'b0;
                `ADDR_RS_FRAC: rs_lock_q <= 1'b0;
                `ADDR_RU_FRAC: ru_lock_q <= 1'b0;
                default: loc_lock_q <= loc_lock_q;
            endcase
        end
    end

    // ==========================================================
    // read data

    reg [7:0] rd_mux;
    always @* begin
        case (reg_addr_in)
            `ADDR_LOCAL_INT: rd_mux = loc_int_q;
            `ADDR_RS_INT: rd_mux = rs_int_q;
            `ADDR_RU_INT: rd_mux = ru_int_q;
            `ADDR_LOCAL_FRAC: rd_mux = loc_lock_q ? loc_hold_q : {loc_frac_q, 5'b00000};
            `ADDR_RS_FRAC: rd_mux = rs_lock_q ? rs_hold_q :
                frac_fmt(rs_frac_q, filt_on);
            `ADDR_RU_FRAC: rd_mux = ru_lock_q ? ru_hold_q :
                frac_fmt(ru_frac_q, filt_on);
            `ADDR_DCFG: rd_mux = dcfg_q;
            `ADDR_GCFG_A, `ADDR_GCFG_B: rd_mux = gcfg_q;
            `ADDR_RATE_A, `ADDR_RATE_B: rd_mux = rate_q;
            `ADDR_OFS_HI: rd_mux = ofs_hi_q;
            `ADDR_OFS_LO: rd_mux = ofs_lo_q;
            `ADDR_ONESHOT: rd_mux = 8'h00;
            default: rd_mux = 8'h00;
        endcase
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_mux;
        end
    end

    // ==========================================================
    // shared pin and alarm outputs

    always @(posedge clk_in) begin
        if (rst_in) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
        end else begin
            pin_s1_q <= addr_select_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    wire ot_alarm;
    wire crit_alarm;
    assign ot_alarm =
        (local_overtemp_in && !gcfg_q[`GCFG_MASK_LOT]) ||
        (remote_overtemp_in && !gcfg_q[`GCFG_MASK_ROT]) ||
        (diode_fault_in && !dcfg_q[`DCFG_FMASK_OT]);
    assign crit_alarm =
        (local_crit_in && !gcfg_q[`GCFG_MASK_LCRIT]) ||
        (remote_crit_in && !gcfg_q[`GCFG_MASK_RCRIT]) ||
        (diode_fault_in && !dcfg_q[`DCFG_FMASK_CRIT]);

    always @(posedge clk_in) begin
        if (rst_in) begin
            overtemp_shutdown_out <= 1'b0;
            overtemp_shutdown_oe_n_out <= 1'b1;
            addr_select_level_out <= 1'b1;
            crit_alarm_out <= 1'b0;
            diode_model_select_out <= 1'b1;
            remote_filter_en_out <= 1'b1;
            standby_out <= 1'b0;
        end else begin
            overtemp_shutdown_out <= 1'b0;
            // pulls low only when the pin acts as the overtemp output
            overtemp_shutdown_oe_n_out <= !(dcfg_q[`DCFG_ROLE] && ot_alarm);
            if (!dcfg_q[`DCFG_ROLE] && pin_s2_q == pin_s3_q) begin
                addr_select_level_out <= pin_s3_q;
            end
            crit_alarm_out <= crit_alarm;
            diode_model_select_out <= dcfg_q[`DCFG_MODEL];
            remote_filter_en_out <= filt_on;
            standby_out <= standby;
        end
    end

endmodule

// [verification/reg_bank_checker.sv]
/* Concurrent checks on the register bank ports.
   Assumes one clock domain and register strobes spaced two edges apart. */
`timescale 1ns/100ps
module reg_bank_checker (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // register access
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // converter and controls
    input wire conv_start_out,
    input wire conv_busy_out,
    input wire conv_done_in,
    input wire diode_model_select_out,
    input wire remote_filter_en_out,
    input wire standby_out
);
    // ==========================================================
    // decodes
    wire wr_dcfg = reg_wr_in && reg_addr_in == 8'hbf;
    wire gcfg_sel = reg_addr_in == 8'h03 || reg_addr_in == 8'h09;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // ==========================================================
    // properties
    start_one_cycle_a: assert property (conv_start_out |=> !conv_start_out)
        else $error("start pulse too long");
    busy_until_done_a: assert property (conv_busy_out && !conv_done_in |=> conv_busy_out)
        else $error("busy dropped early");
    done_ends_busy_a: assert property (conv_busy_out && conv_done_in |=> !conv_busy_out)
        else $error("busy kept after done");
    model_select_a: assert property (wr_dcfg |-> ##2 diode_model_select_out == $past(reg_wdata_in[3], 2))
        else $error("model select wrong");
    filter_enable_a: assert property (wr_dcfg |-> ##2 remote_filter_en_out == ($past(reg_wdata_in[2:1], 2) == 2'b11))
        else $error("filter enable wrong");
    standby_follow_a: assert property (reg_wr_in && gcfg_sel |-> ##2 standby_out == $past(reg_wdata_in[6], 2))
        else $error("standby wrong");
    oneshot_zero_a: assert property (reg_rd_in && reg_addr_in == 8'h0f |-> ##2 reg_rdata_out == 8'h00)
        else $error("trigger code read not zero");
    dcfg_fixed_a: assert property (reg_rd_in && reg_addr_in == 8'hbf |-> ##2 reg_rdata_out[7] == 1'b0 && reg_rdata_out[0] == 1'b1)
        else $error("diode config fixed bits wrong");
    gcfg_reserved_a: assert property (reg_rd_in && gcfg_sel |-> ##2 (reg_rdata_out & 8'ha1) == 8'h00)
        else $error("config reserved bits set");
    no_free_start_a: assert property (conv_start_out && standby_out && $past(standby_out) |-> $past(reg_wr_in && reg_addr_in == 8'h0f))
        else $error("start in standby without trigger");
endmodule
bind temp_sensor_reg_bank reg_bank_checker chk_i (.clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
    .reg_wdata_in, .reg_rd_in, .reg_rdata_out, .conv_start_out, .conv_busy_out, .conv_done_in,
    .diode_model_select_out, .remote_filter_en_out, .standby_out);

// [verification/conv_model.sv]
/* Behavioural converter answering each start after a set latency.
   Assumes starts come only while idle; results are valid with done only. */
`timescale 1ns/100ps
module conv_model (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // request and settings
    input wire start_in,
    input wire [7:0] lat_in,
    input wire [10:0] loc_in,
    input wire [14:0] rem_in,
    // answer
    output reg done_out,
    output wire [10:0] loc_out,
    output wire [14:0] rem_out
);
    reg [7:0] cnt_q;
    // off the done pulse the buses show the inverse, so stale capture shows up
    assign loc_out = done_out ? loc_in : ~loc_in;
    assign rem_out = done_out ? rem_in : ~rem_in;
    always @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= 8'h00;
            done_out <= 1'b0;
        end else begin
            done_out <= cnt_q == 8'h01;
            if (start_in)
                cnt_q <= lat_in;
            else if (cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule

// [verification/tb_top.sv]
/* Self-checking bench for the temperature register bank.
   Assumes the converter model on the far side; intervals are shortened. */
`timescale 1ns/100ps
module tb_top;
    localparam [29:0] R1 = 30'd40;
    localparam [29:0] R2 = 30'd100;
    localparam [29:0] R3 = 30'd250;
    localparam [143:0] RST_TBL = 144'h0300_0900_0402_0a02_1100_1200_bf1f_0f00_5500;
    reg clk_in = 1'b0;
    reg rst_in = 1'b1;
    reg [7:0] reg_addr_in = 8'h00;
    reg reg_wr_in = 1'b0;
    reg [7:0] reg_wdata_in = 8'h00;
    reg reg_rd_in = 1'b0;
    reg diode_fault_in = 1'b0;
    reg addr_select_pin_in = 1'b1;
    reg [3:0] cmp = 4'h0;
    reg [7:0] lat = 8'h08;
    reg [10:0] loc = 11'h000;
    reg [14:0] rem = 15'h0000;
    wire [7:0] reg_rdata_out;
    wire conv_start_out, conv_busy_out, conv_done_in, diode_model_select_out;
    wire remote_filter_en_out, standby_out, overtemp_shutdown_oe_n_out;
    wire addr_select_level_out, crit_alarm_out, overtemp_shutdown_out;
    wire [10:0] local_raw_in;
    wire [14:0] remote_raw_in;
    integer n_mismatch = 0;
    integer n_compared = 0;
    integer seed = 32'h40d9;
    integer i, n, g;
    reg [31:0] rnd;
    reg [14:0] rr;
    reg [10:0] ofs;
    reg [47:0] e, ea;
    always #2 clk_in = ~clk_in;
    temp_sensor_reg_bank #(.RATE1_CYCLES(R1), .RATE2_CYCLES(R2), .RATE3_CYCLES(R3)) DUT (
        .clk_in, .rst_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rd_in, .reg_rdata_out,
        .conv_start_out, .conv_busy_out, .conv_done_in, .local_raw_in, .remote_raw_in,
        .diode_fault_in, .local_overtemp_in(cmp[0]), .local_crit_in(cmp[1]),
        .remote_overtemp_in(cmp[2]), .remote_crit_in(cmp[3]), .diode_model_select_out,
        .remote_filter_en_out, .standby_out, .addr_select_pin_in, .overtemp_shutdown_out,
        .overtemp_shutdown_oe_n_out, .addr_select_level_out, .crit_alarm_out);
    conv_model CONV (.clk_in, .rst_in, .start_in(conv_start_out), .lat_in(lat), .loc_in(loc),
        .rem_in(rem), .done_out(conv_done_in), .loc_out(local_raw_in), .rem_out(remote_raw_in));
    // ==========================================================
    // expected results: {local, signed remote, unsigned remote}, int then fraction
    function [47:0] expect_res(input [10:0] l, input [14:0] r, input [10:0] o, input f,
                               input flt);
        reg [16:0] s;
        reg [7:0] si, ui;
        reg [4:0] sf, uf;
        begin
            s = {{2{r[14]}}, r} + {{4{o[10]}}, o, 2'b00};
            si = s[12:5];
            sf = s[4:0];
            ui = s[12:5];
            uf = s[4:0];
            // out of range results saturate at the ends of each format
            if (s[16] && !(&s[15:12])) begin
                si = 8'h80;
                sf = 5'h00;
            end else if (!s[16] && (|s[15:12])) begin
                si = 8'h7f;
                sf = 5'h1f;
            end
            if (s[16]) begin
                ui = 8'h00;
                uf = 5'h00;
            end else if (|s[15:13]) begin
                ui = 8'hff;
                uf = 5'h1f;
            end
            expect_res = {l[10:3], l[2:0], 5'h00, si, f ? {sf, 3'h0} : {sf[4:2], 5'h00},
                          ui, f ? {uf, 3'h0} : {uf[4:2], 5'h00}};
            if (flt)
                expect_res[31:0] = 32'h8000_0000;
        end
    endfunction
    // ==========================================================
    // bus and check tasks
    task conclude;
        begin
            if (n_mismatch == 0 && n_compared > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk(input string nm, input [7:0] ex, input [7:0] got);
        begin
            n_compared = n_compared + 1;
            if (got !== ex) begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk_in);
            reg_addr_in <= a;
            reg_wdata_in <= d;
            reg_wr_in <= 1'b1;
            @(posedge clk_in);
            reg_wr_in <= 1'b0;
        end
    endtask
    task rdchk(input string nm, input [7:0] a, input [7:0] ex);
        begin
            @(posedge clk_in);
            reg_addr_in <= a;
            reg_rd_in <= 1'b1;
            @(posedge clk_in);
            reg_rd_in <= 1'b0;
            @(posedge clk_in);
            #1 chk(nm, ex, reg_rdata_out);
        end
    endtask
    task wait_idle;
        begin
            n = 0;
            while (conv_busy_out !== 1'b0 && n < 500) begin
                @(posedge clk_in);
                #1 n = n + 1;
            end
            chk("idle", 8'h01, {7'h0, n < 500});
        end
    endtask
    task next_start;
        begin
            n = 0;
            do begin
                @(posedge clk_in);
                #1 n = n + 1;
            end while (conv_start_out !== 1'b1 && n < 1000);
        end
    endtask
    task conv(input [10:0] l, input [14:0] r, input f);
        begin
            wait_idle;
            @(posedge clk_in);
            loc <= l;
            rem <= r;
            diode_fault_in <= f;
            wr(8'h0f, 8'ha5);
            repeat (2) @(posedge clk_in);
            #1 wait_idle;
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rnd = $random(seed);
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 9; i = i + 1)
            rdchk("reset", RST_TBL[16*i+8 +: 8], RST_TBL[16*i +: 8]);
        wr(8'hbf, 8'h80);
        rdchk("dcfg", 8'hbf, 8'h01);
        for (i = 0; i < 6; i = i + 1) begin
            rnd = $random(seed);
            wr(8'h03, rnd[7:0]);
            rdchk("gcfg", 8'h09, rnd[7:0] & 8'h5e);
            chk("standby", {7'h0, rnd[6]}, {7'h0, standby_out});
            wr(8'h0a, rnd[15:8]);
            rdchk("rate", 8'h04, rnd[15:8] & 8'h03);
            wr(8'h11, rnd[23:16]);
            rdchk("ofs_hi", 8'h11, rnd[23:16]);
            wr(8'h12, rnd[31:24]);
            rdchk("ofs_lo", 8'h12, rnd[31:24] & 8'he0);
            wr(8'hbf, rnd[7:0]);
            rdchk("dcfg", 8'hbf, (rnd[7:0] & 8'h7e) | 8'h01);
            chk("model", {7'h0, rnd[3]}, {7'h0, diode_model_select_out});
            chk("filter", {7'h0, rnd[2:1] == 2'b11}, {7'h0, remote_filter_en_out});
        end
        wr(8'h03, 8'h40);
        for (i = 0; i < 8; i = i + 1) begin
            rnd = $random(seed);
            ofs = {{4{rnd[3]}}, rnd[3:0], rnd[6:4]};
            rr = (i == 6) ? 15'h7c00 : {4'h0, rnd[31:21]};
            @(posedge clk_in);
            lat <= (i == 1) ? 8'h01 : {4'h0, rnd[11:8]} + 8'h01;
            wr(8'h11, ofs[10:3]);
            wr(8'h12, {ofs[2:0], 5'h00});
            wr(8'hbf, i[0] ? 8'h1f : 8'h19);
            conv(rnd[22:12], rr, i == 5);
            e = expect_res(rnd[22:12], rr, ofs, i[0], i == 5);
            rdchk("loc_int", 8'h00, e[47:40]);
            rdchk("loc_frac", 8'h30, e[39:32]);
            rdchk("rs_int", 8'h01, e[31:24]);
            rdchk("rs_frac", 8'h10, e[23:16]);
            rdchk("ru_int", 8'h31, e[15:8]);
            rdchk("ru_frac", 8'h32, e[7:0]);
        end
        // newer conversions land between integer and fraction reads
        conv(11'h0a0, 15'h0401, 1'b0);
        ea = expect_res(11'h0a0, 15'h0401, ofs, 1'b1, 1'b0);
        rdchk("rs_int", 8'h01, ea[31:24]);
        conv(11'h0a0, 15'h0402, 1'b0);
        e = expect_res(11'h0a0, 15'h0402, ofs, 1'b1, 1'b0);
        rdchk("rs_frac_lock", 8'h10, ea[23:16]);
        rdchk("rs_frac_live", 8'h10, e[23:16]);
        rdchk("ru_int", 8'h31, e[15:8]);
        conv(11'h0a0, 15'h0403, 1'b0);
        ea = expect_res(11'h0a0, 15'h0403, ofs, 1'b1, 1'b0);
        rdchk("ru_int", 8'h31, ea[15:8]);
        conv(11'h0a0, 15'h0404, 1'b0);
        rdchk("ru_frac_lock", 8'h32, ea[7:0]);
        @(posedge clk_in);
        lat <= 8'h08;
        wr(8'h03, 8'h00);
        for (i = 3; i >= 0; i = i - 1) begin
            // continuous: latency 8, then done, return to wait and restart edges
            g = (i == 3) ? R3 : (i == 2) ? R2 : (i == 1) ? R1 : 11;
            wr(8'h04, i[7:0]);
            next_start;
            next_start;
            next_start;
            chk("interval", 8'h01, {7'h0, n == g});
        end
        wr(8'h03, 8'h40);
        repeat (2) @(posedge clk_in);
        #1 wait_idle;
        next_start;
        chk("no_start", 8'h01, {7'h0, n == 1000});
        @(posedge clk_in);
        cmp <= 4'b1001;
        repeat (6) @(posedge clk_in);
        #1 chk("crit", 8'h01, {7'h0, crit_alarm_out});
        wr(8'h03, 8'h50);
        wr(8'hbf, 8'h5f);
        repeat (6) @(posedge clk_in);
        #1 chk("crit_mask", 8'h00, {7'h0, crit_alarm_out});
        chk("os_drive", 8'h00, {7'h0, overtemp_shutdown_oe_n_out});
        chk("os_data", 8'h00, {7'h0, overtemp_shutdown_out});
        wr(8'hbf, 8'h1f);
        addr_select_pin_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        #1 chk("os_off", 8'h01, {7'h0, overtemp_shutdown_oe_n_out});
        chk("addr_pin", 8'h00, {7'h0, addr_select_level_out});
        conclude;
    end
    // about seventeen times the expected run length
    initial begin
        #200000;
        n_mismatch = n_mismatch + 1;
        conclude;
    end
endmodule
